// >>> design/spi_link_pkg.sv
// What this block does
// - device is slave only, never drives clock
// - master gives one select per slave
// - select low during transaction, high after
// - serial out high-impedance while deselected
// - bytes shifted most significant bit first
// - receiver captures on serial clock rise
// - transmitter changes output on falling edge
// - general access clock at most 1MHz
// - 20MHz only for sensor/interrupt reads
// - transaction is command plus data bytes
// - command bit7: 1 read, 0 write
// - seven address bits, eight data bits
// - single and burst transfers accepted
// - burst write increments register address
package spi_link_pkg;
   localparam int unsigned ADDR_W       = 7;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned BIT_CNT_W    = 3;
   localparam int unsigned RW_BIT       = 7;
   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned SCLK_GEN_HZ  = 1_000_000;
   // half period rounded down, so the rate can come out above the limit
   localparam int unsigned HALF_DIV_RAW = CLK_HZ / (2 * SCLK_GEN_HZ);
   localparam int unsigned HALF_DIV     = (HALF_DIV_RAW < 1) ? 1 : HALF_DIV_RAW;
   localparam int unsigned DIV_W        = 8;
   localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
   localparam logic [DIV_W-1:0]     DIV_LAST = DIV_W'(HALF_DIV - 1);
endpackage : spi_link_pkg

// >>> design/spi_link_if.sv
interface spi_link_if;
   logic sclk;
   logic cs_n;
   logic slave_serial_in;
   logic so_out;
   logic so_oe;
   // wire level of the shared output line as the master sees it
   // released line reads low, as with a pull-down
   logic slave_serial_out;
   assign slave_serial_out = so_oe & so_out;

   modport device (
      input  sclk,
      input  cs_n,
      input  slave_serial_in,
      output so_out,
      output so_oe
   );
   modport master (
      output sclk,
      output cs_n,
      output slave_serial_in,
      input  slave_serial_out
   );
endinterface : spi_link_if

// >>> design/spi_reg_slave.sv
module spi_reg_slave
   import spi_link_pkg::*;
(
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      nrst,
   // serial link
   spi_link_if.device                     link,
   // register file side
   output logic                           wr_pulse,
   output logic [spi_link_pkg::ADDR_W-1:0] wr_addr,
   output logic [spi_link_pkg::DATA_W-1:0] wr_data,
   output logic [spi_link_pkg::ADDR_W-1:0] rd_addr,
   input  wire logic [spi_link_pkg::DATA_W-1:0] rd_data
);
   import spi_link_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CMD  = 3'b010,
      ST_DATA = 3'b100
   } slv_state_t;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers, first stage read only by the second
   logic [2:0] s1_reg, s2_reg;
   logic       sclk_d_reg;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         // idle levels: select high, clock low, so no false edge follows reset
         s1_reg     <= 3'h4;
         s2_reg     <= 3'h4;
         sclk_d_reg <= 1'b0;
      end else begin
         s1_reg     <= {link.cs_n, link.sclk, link.slave_serial_in};
         s2_reg     <= s1_reg;
         sclk_d_reg <= s2_reg[1];
      end
   end
   wire cs_n_s = s2_reg[2];
   wire sdi_s  = s2_reg[0];
   wire rise   = s2_reg[1] & ~sclk_d_reg;
   wire fall   = ~s2_reg[1] & sclk_d_reg;

   ////////////////////////////////////////////////////////////////////////
   slv_state_t             state_reg, state_next;
   logic [BIT_CNT_W-1:0]   cnt_reg, cnt_next;
   logic [DATA_W-1:0]      sh_reg, sh_next;
   logic [DATA_W-1:0]      tx_reg, tx_next;
   logic [ADDR_W-1:0]      addr_reg, addr_next;
   logic                   rd_reg, rd_next;
   logic                   so_reg, so_next;
   logic                   oe_reg, oe_next;
   logic                   wp_reg, wp_next;
   logic [DATA_W-1:0]      wd_reg, wd_next;
   logic [ADDR_W-1:0]      wa_reg, wa_next;
   logic                   load_reg, load_next;

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      sh_next    = sh_reg;
      tx_next    = tx_reg;
      addr_next  = addr_reg;
      rd_next    = rd_reg;
      so_next    = so_reg;
      oe_next    = oe_reg;
      wp_next    = 1'b0;
      wd_next    = wd_reg;
      wa_next    = wa_reg;
      load_next  = 1'b0;
      // registered read data becomes available one cycle after address set
      if (load_reg) begin
         tx_next = rd_data;
      end
      case (state_reg)
         ST_IDLE: begin
            oe_next = 1'b0;
            so_next = 1'b0;
            if (!cs_n_s) begin
               state_next = ST_CMD;
               cnt_next   = '0;
            end
         end
         ST_CMD: begin
            if (rise) begin
               sh_next  = {sh_reg[DATA_W-2:0], sdi_s};
               cnt_next = cnt_reg + 1'b1;
               if (cnt_reg == BIT_LAST) begin
                  rd_next    = sh_reg[RW_BIT-1];
                  addr_next  = {sh_reg[ADDR_W-2:0], sdi_s};
                  state_next = ST_DATA;
                  load_next  = 1'b1;
               end
            end
         end
         ST_DATA: begin
            // first data bit goes out on the fall that ends the command byte
            if (fall && rd_reg) begin
               oe_next = 1'b1;
               so_next = tx_reg[BIT_LAST - cnt_reg];
            end
            if (rise) begin
               sh_next  = {sh_reg[DATA_W-2:0], sdi_s};
               cnt_next = cnt_reg + 1'b1;
               if (cnt_reg == BIT_LAST) begin
                  if (!rd_reg) begin
                     wp_next = 1'b1;
                     wa_next = addr_reg;
                     wd_next = {sh_reg[DATA_W-2:0], sdi_s};
                  end
                  addr_next = addr_reg + 1'b1;
                  load_next = 1'b1;
               end
            end
         end
         default: state_next = ST_IDLE;
      endcase
      // select high ends any transfer at once
      if (cs_n_s) begin
         state_next = ST_IDLE;
         oe_next    = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= '0;
         sh_reg    <= '0;
         tx_reg    <= '0;
         addr_reg  <= '0;
         rd_reg    <= 1'b0;
         so_reg    <= 1'b0;
         oe_reg    <= 1'b0;
         wp_reg    <= 1'b0;
         wd_reg    <= '0;
         wa_reg    <= '0;
         load_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         sh_reg    <= sh_next;
         tx_reg    <= tx_next;
         addr_reg  <= addr_next;
         rd_reg    <= rd_next;
         so_reg    <= so_next;
         oe_reg    <= oe_next;
         wp_reg    <= wp_next;
         wd_reg    <= wd_next;
         wa_reg    <= wa_next;
         load_reg  <= load_next;
      end
   end

   assign link.so_out = so_reg;
   assign link.so_oe  = oe_reg;
   assign wr_pulse    = wp_reg;
   assign wr_addr     = wa_reg;
   assign wr_data     = wd_reg;
   assign rd_addr     = addr_reg;
endmodule : spi_reg_slave

// >>> design/spi_reg_master.sv
module spi_reg_master
   import spi_link_pkg::*;
(
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       nrst,
   // serial link
   spi_link_if.master                      link,
   // user request side
   input  wire logic                       start,
   input  wire logic                       rd_req,
   input  wire logic [spi_link_pkg::ADDR_W-1:0] addr,
   input  wire logic [spi_link_pkg::DATA_W-1:0] tx_data,
   input  wire logic                       more,
   output logic                            busy,
   output logic                            byte_done,
   output logic [spi_link_pkg::DATA_W-1:0] rx_data,
   output logic                            tx_take
);
   import spi_link_pkg::*;

   typedef enum logic [2:0] {
      M_IDLE = 3'b001,
      M_LOW  = 3'b010,
      M_HIGH = 3'b100
   } mst_state_t;

   ////////////////////////////////////////////////////////////////////////
   logic m1_reg, m2_reg; // slow input sync, stage one read by stage two only
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         m1_reg <= 1'b0;
         m2_reg <= 1'b0;
      end else begin
         m1_reg <= link.slave_serial_out;
         m2_reg <= m1_reg;
      end
   end
   wire miso_s = m2_reg;

   ////////////////////////////////////////////////////////////////////////
   mst_state_t           st_reg, st_next;
   logic [DIV_W-1:0]     div_reg, div_next;
   logic [BIT_CNT_W-1:0] bit_reg, bit_next;
   logic [DATA_W-1:0]    sh_reg, sh_next;
   logic [DATA_W-1:0]    rx_reg, rx_next;
   logic                 sclk_reg, sclk_next;
   logic                 cs_reg, cs_next;
   logic                 mo_reg, mo_next;
   logic                 done_reg, done_next;
   logic                 take_reg, take_next;
   logic                 cmd_reg, cmd_next;

   always_comb begin
      st_next   = st_reg;
      div_next  = div_reg;
      bit_next  = bit_reg;
      sh_next   = sh_reg;
      rx_next   = rx_reg;
      sclk_next = sclk_reg;
      cs_next   = cs_reg;
      mo_next   = mo_reg;
      done_next = 1'b0;
      take_next = 1'b0;
      cmd_next  = cmd_reg;
      case (st_reg)
         M_IDLE: begin
            sclk_next = 1'b0;
            cs_next   = 1'b1;
            if (start) begin
               cs_next   = 1'b0;
               sh_next   = {rd_req, addr};
               mo_next   = rd_req;
               cmd_next  = 1'b1;
               bit_next  = '0;
               div_next  = '0;
               st_next   = M_LOW;
            end
         end
         M_LOW: begin
            if (div_reg == DIV_LAST) begin
               div_next  = '0;
               sclk_next = 1'b1;
               sh_next   = {sh_reg[DATA_W-2:0], miso_s};
               st_next   = M_HIGH;
            end else begin
               div_next = div_reg + 1'b1;
            end
         end
         M_HIGH: begin
            if (div_reg == DIV_LAST) begin
               div_next  = '0;
               sclk_next = 1'b0;
               bit_next  = bit_reg + 1'b1;
               st_next   = M_LOW;
               mo_next   = sh_reg[DATA_W-1];
               if (bit_reg == BIT_LAST) begin
                  if (!cmd_reg) begin
                     rx_next   = sh_reg;
                     done_next = 1'b1;
                  end
                  // every transaction carries at least one data byte
                  if (cmd_reg || more) begin
                     cmd_next  = 1'b0;
                     take_next = 1'b1;
                     sh_next   = tx_data;
                     mo_next   = tx_data[DATA_W-1];
                  end else begin
                     cs_next = 1'b1;
                     st_next = M_IDLE;
                  end
               end
            end else begin
               div_next = div_reg + 1'b1;
            end
         end
         default: st_next = M_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_reg   <= M_IDLE;
         div_reg  <= '0;
         bit_reg  <= '0;
         sh_reg   <= '0;
         rx_reg   <= '0;
         sclk_reg <= 1'b0;
         cs_reg   <= 1'b1;
         mo_reg   <= 1'b0;
         done_reg <= 1'b0;
         take_reg <= 1'b0;
         cmd_reg  <= 1'b0;
      end else begin
         st_reg   <= st_next;
         div_reg  <= div_next;
         bit_reg  <= bit_next;
         sh_reg   <= sh_next;
         rx_reg   <= rx_next;
         sclk_reg <= sclk_next;
         cs_reg   <= cs_next;
         mo_reg   <= mo_next;
         done_reg <= done_next;
         take_reg <= take_next;
         cmd_reg  <= cmd_next;
      end
   end

   assign link.sclk            = sclk_reg;
   assign link.cs_n            = cs_reg;
   assign link.slave_serial_in = mo_reg;
   assign busy                 = (st_reg != M_IDLE);
   assign byte_done            = done_reg;
   assign rx_data              = rx_reg;
   assign tx_take              = take_reg;
endmodule : spi_reg_master

// >>> dv/spi_link_props.sv
module spi_link_props (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic slave_serial_in,
   input wire logic so_out,
   input wire logic so_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   import spi_link_pkg::*;
   logic             sclk_reg;
   logic             rise;
   logic             rw_reg, rw_next;
   logic [DIV_W-1:0] ph_reg, ph_next;
   logic [9:0]       cnt_reg, cnt_next;
   ////////////////////////////////////////////////////////////////////////////////
   assign rise = sclk & ~sclk_reg & ~cs_n;
   always_comb begin
      // saturate so a long idle never wraps into a short phase
      ph_next  = (sclk != sclk_reg) ? '0 : ph_reg + DIV_W'(ph_reg != '1);
      cnt_next = cs_n ? '0 : cnt_reg + 10'(rise);
      rw_next  = (rise && cnt_reg == '0) ? slave_serial_in : rw_reg;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sclk_reg <= 1'b0;
         ph_reg   <= '0;
         cnt_reg  <= '0;
         rw_reg   <= 1'b0;
      end else begin
         sclk_reg <= sclk;
         ph_reg   <= ph_next;
         cnt_reg  <= cnt_next;
         rw_reg   <= rw_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking dc @(posedge clock); endclocking
   default disable iff (!nrst);
   // slave sees select through two flops, so allow a short tail
   property p_hiz;
      cs_n [*4] |-> !so_oe;
   endproperty
   a_hiz: assert property (p_hiz) else $error("output driven while deselected");
   property p_drop;
      $fell(so_oe) |-> cs_n;
   endproperty
   a_drop: assert property (p_drop) else $error("output released inside frame");
   property p_sdi;
      $rose(sclk) |-> $stable(slave_serial_in);
   endproperty
   a_sdi: assert property (p_sdi) else $error("data in moved at clock rise");
   property p_so;
      $rose(sclk) && so_oe |-> $stable(so_out);
   endproperty
   a_so: assert property (p_so) else $error("data out moved at clock rise");
   property p_ph;
      (sclk != sclk_reg) && !cs_n |-> ph_reg >= DIV_LAST;
   endproperty
   a_ph: assert property (p_ph) else $error("serial clock phase too short");
   property p_len;
      $rose(cs_n) |-> cnt_reg >= 10'h010 && cnt_reg[2:0] == 3'h0;
   endproperty
   a_len: assert property (p_len) else $error("frame not whole bytes");
   property p_rd;
      so_oe && !cs_n |-> rw_reg && cnt_reg >= 10'h008;
   endproperty
   a_rd: assert property (p_rd) else $error("output driven outside read data");
   property p_lead;
      $fell(cs_n) |-> !sclk [*8];
   endproperty
   a_lead: assert property (p_lead) else $error("clock rose right after select");
   c_read: cover property ($rose(so_oe));
   c_single: cover property ($rose(cs_n) && cnt_reg == 10'h010);
   c_burst: cover property ($rose(cs_n) && cnt_reg >= 10'h020);
endmodule // spi_link_props

// >>> dv/tb_sensor_spi_register_slave.sv
module tb_sensor_spi_register_slave;
   timeunit 1ns;
   timeprecision 100ps;
   import spi_link_pkg::*;
   logic              clock, nrst, start, rd_req, more, sclk_seen;
   logic              busy, byte_done, tx_take, wr_pulse, ab_wr;
   logic [ADDR_W-1:0] addr, wr_addr, rd_addr;
   logic [DATA_W-1:0] tx_data, rx_data, wr_data, rd_data, cur, sh, cmd_exp;
   logic [DATA_W-1:0] mem [128];
   logic [14:0]       wq [$];
   logic [DATA_W-1:0] rq [$];
   int                n_errors = 0;
   int                checked = 0;
   int                ab_cnt = 0;
   int                nb = 0;
   spi_link_if link_a();
   spi_link_if link_b();
   assign rd_data = mem[rd_addr];
   ////////////////////////////////////////////////////////////////////////////////
   spi_reg_master spi_reg_master_inst (.clock(clock), .nrst(nrst), .link(link_a),
      .start(start), .rd_req(rd_req), .addr(addr), .tx_data(tx_data), .more(more),
      .busy(busy), .byte_done(byte_done), .rx_data(rx_data), .tx_take(tx_take));
   spi_reg_slave spi_reg_slave_inst (.clock(clock), .nrst(nrst), .link(link_a),
      .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
      .rd_data(rd_data));
   // second end faces a rule-breaking bench driver
   spi_reg_slave spi_reg_slave_inst_b (.clock(clock), .nrst(nrst), .link(link_b),
      .wr_pulse(ab_wr), .wr_addr(), .wr_data(), .rd_addr(), .rd_data(8'h00));
   spi_link_props spi_link_props_inst (.clock(clock), .nrst(nrst), .sclk(link_a.sclk),
      .cs_n(link_a.cs_n), .slave_serial_in(link_a.slave_serial_in),
      .so_out(link_a.so_out), .so_oe(link_a.so_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic test_done;
      if (n_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input int n);
      cur = DATA_W'($urandom);
      cmd_exp = {rd, a};
      start   <= 1'b1;
      rd_req  <= rd;
      addr    <= a;
      tx_data <= cur;
      more    <= (n > 1);
      @(posedge clock iff busy === 1'b1);
      start <= 1'b0;
      for (int k = 0; k < n; k++) begin
         @(posedge clock iff tx_take === 1'b1);
         if (rd) rq.push_back(mem[ADDR_W'(a + k)]);
         else wq.push_back({ADDR_W'(a + k), cur});
         cur = DATA_W'($urandom);
         tx_data <= cur;
         more    <= (k < n - 1);
      end
      @(posedge clock iff busy === 1'b0);
      repeat (8) @(posedge clock);
   endtask
   task automatic bang(input logic [15:0] v, input int bits);
      link_b.cs_n <= 1'b0;
      for (int i = 0; i < bits; i++) begin
         link_b.slave_serial_in <= v[15 - i];
         repeat (20) @(posedge clock);
         link_b.sclk <= 1'b1;
         repeat (20) @(posedge clock);
         link_b.sclk <= 1'b0;
      end
      repeat (20) @(posedge clock);
      link_b.cs_n <= 1'b1;
      link_b.slave_serial_in <= ~v[16 - bits];
      repeat (20) @(posedge clock);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      if (wr_pulse === 1'b1) begin
         mem[wr_addr] <= wr_data;
         chk(wq.size() > 0 && wq[0] === {wr_addr, wr_data}, "write");
         if (wq.size() > 0) void'(wq.pop_front());
      end
      if (byte_done === 1'b1 && rq.size() > 0) begin
         chk(rq[0] === rx_data, "read");
         void'(rq.pop_front());
      end
      if (ab_wr === 1'b1) ab_cnt++;
      // wire-level view of the command byte
      if (link_a.sclk && !sclk_seen && !link_a.cs_n) begin
         sh = {sh[6:0], link_a.slave_serial_in};
         nb++;
         if (nb == 8) chk(sh === cmd_exp, "command");
      end
      if (link_a.cs_n) nb = 0;
      sclk_seen = link_a.sclk;
   end
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      repeat (40000) @(posedge clock);
      n_errors++;
      test_done();
   end
   initial begin
      void'($urandom(32'h9014));
      foreach (mem[i]) mem[i] = DATA_W'($urandom);
      nrst = 1'b0;
      start = 1'b0;
      rd_req = 1'b0;
      addr = '0;
      tx_data = '0;
      more = 1'b0;
      sclk_seen = 1'b0;
      link_b.cs_n = 1'b1;
      link_b.sclk = 1'b0;
      link_b.slave_serial_in = 1'b0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      xfer(1'b0, 7'h15, 1);
      xfer(1'b1, 7'h15, 1);
      xfer(1'b0, 7'h7e, 4);
      xfer(1'b1, 7'h7d, 5);
      repeat (6) xfer(1'($urandom), ADDR_W'($urandom), 1 + int'($urandom_range(2)));
      // partial byte must be dropped, a whole one kept
      bang(16'h05a5, 12);
      bang(16'h05a5, 16);
      chk(ab_cnt == 1, "abort");
      chk(wq.size() == 0 && rq.size() == 0, "lost byte");
      test_done();
   end
endmodule // tb_sensor_spi_register_slave
